// ### logic/haptic_loop_pkg.sv
`default_nettype none

package haptic_loop_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 10000;
  localparam int unsigned TICK_TIME_PS  = 98490000;  // 98.49 us.
  localparam int unsigned TICK_CYCLES   = TICK_TIME_PS / CLK_PERIOD_PS;
  localparam logic [7:0]  BOOST_TICKS   = 8'h04;
  localparam logic [7:0]  BRAKE_NEAR    = 8'h08;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_RATED  = 8'h16;
  localparam logic [7:0] ADDR_CLAMP  = 8'h17;
  localparam logic [7:0] ADDR_COMP   = 8'h18;
  localparam logic [7:0] ADDR_BEMF   = 8'h19;
  localparam logic [7:0] ADDR_FBCTL  = 8'h1a;
  localparam logic [7:0] ADDR_CTL1   = 8'h1b;
  localparam logic [7:0] ADDR_CTL2   = 8'h1c;
  localparam logic [7:0] ADDR_CTL5   = 8'h1f;
  localparam logic [7:0] ADDR_OLPER  = 8'h20;
  localparam logic [7:0] ADDR_PERIOD = 8'h22;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ST_FAULT_BIT = 3;
  localparam int FB_TYPE_BIT  = 7;
  localparam int FB_BRAKE_LSB = 4;
  localparam int FB_GAIN_LSB  = 2;
  localparam int C1_BOOST_BIT = 7;
  localparam int C2_STAB_BIT  = 6;
  localparam int C5_CNT_LSB   = 6;
  localparam int C5_AUTO_BIT  = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_RATED = 8'h80;
  localparam logic [7:0] RST_CLAMP = 8'hc0;
  localparam logic [7:0] RST_COMP  = 8'h00;
  localparam logic [7:0] RST_BEMF  = 8'h80;
  localparam logic [7:0] RST_FBCTL = 8'h00;
  localparam logic [7:0] RST_CTL1  = 8'h10;
  localparam logic [7:0] RST_CTL2  = 8'h01;
  localparam logic [7:0] RST_CTL5  = 8'h00;
  localparam logic [6:0] RST_OLPER = 7'h20;

  // Loop operating modes.
  typedef enum logic [1:0] {
    LOOP_IDLE,
    LOOP_CLOSED,
    LOOP_FALLBACK,
    LOOP_OPEN
  } loop_mode_t;

endpackage

`default_nettype wire

// ### logic/haptic_closed_loop_control.sv
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module haptic_closed_loop_control
  import haptic_loop_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  input  wire logic       play_start,
  input  wire logic       drive_on,
  input  wire logic [7:0] drive_level,
  input  wire logic       bemf_valid,
  input  wire logic       bemf_zc,
  input  wire logic [7:0] bemf_mag,
  input  wire logic       cal_done,
  input  wire logic       cal_fail,
  input  wire logic [7:0] cal_comp,
  input  wire logic [7:0] cal_bemf,
  input  wire logic       diag_done,
  input  wire logic       diag_fault,
  output var  logic [7:0] out_amp,
  output var  logic       out_pol,
  output var  logic       out_brake,
  output var  loop_mode_t loop_mode
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]  rated_reg;
  logic [7:0]  clamp_reg;
  logic [7:0]  comp_reg;
  logic [7:0]  bemf_norm_factor;
  logic [7:0]  fbctl_reg;
  logic [7:0]  ctl1_reg;
  logic [7:0]  ctl2_reg;
  logic [7:0]  ctl5_reg;
  logic [6:0]  fixed_drive_period;
  logic [7:0]  period_reg;
  logic        fault_result_flag;
  logic [13:0] tick_cnt_reg;
  logic        tick;
  logic [7:0]  hcnt_reg;
  logic [1:0]  unsync_reg;
  logic [7:0]  boost_reg;
  logic        pol_reg;
  logic        actuator_type_select;
  logic        auto_fallback_enable;
  logic [1:0]  unsync_cycle_limit;
  logic [1:0]  zero_cross_window;
  logic [2:0]  brake_gain_ratio;
  logic [4:0]  drive_time;
  logic [7:0]  fb_half;
  logic [7:0]  open_half;
  logic        sync;
  logic        timeout;
  logic        open_due;
  logic        comm;
  logic [7:0]  amp_next;
  logic        brake_next;

  // Field extraction from configuration registers.
  assign actuator_type_select = fbctl_reg[FB_TYPE_BIT];
  assign brake_gain_ratio     = fbctl_reg[FB_BRAKE_LSB +: 3];
  assign drive_time           = ctl1_reg[4:0];
  assign zero_cross_window    = ctl2_reg[1:0];
  assign auto_fallback_enable = ctl5_reg[C5_AUTO_BIT];
  assign unsync_cycle_limit   = ctl5_reg[C5_CNT_LSB +: 2];

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------

  // Software writes; a good calibration overrides the two factors.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rated_reg          <= RST_RATED;
      clamp_reg          <= RST_CLAMP;
      comp_reg           <= RST_COMP;
      bemf_norm_factor   <= RST_BEMF;
      fbctl_reg          <= RST_FBCTL;
      ctl1_reg           <= RST_CTL1;
      ctl2_reg           <= RST_CTL2;
      ctl5_reg           <= RST_CTL5;
      fixed_drive_period <= RST_OLPER;
    end else if (ce) begin
      if (reg_wr) begin
        unique case (reg_addr)
          ADDR_RATED: rated_reg <= reg_wdata;
          ADDR_CLAMP: clamp_reg <= reg_wdata;
          ADDR_COMP:  comp_reg <= reg_wdata;
          ADDR_BEMF:  bemf_norm_factor <= reg_wdata;
          ADDR_FBCTL: fbctl_reg <= reg_wdata;
          ADDR_CTL1:  ctl1_reg <= reg_wdata;
          ADDR_CTL2:  ctl2_reg <= reg_wdata;
          ADDR_CTL5:  ctl5_reg <= reg_wdata;
          ADDR_OLPER: fixed_drive_period <= reg_wdata[6:0];
          default: ;
        endcase
      end
      if (cal_done && !cal_fail) begin
        comp_reg         <= cal_comp;
        bemf_norm_factor <= cal_bemf;
      end
    end
  end

  // Fault flag: hardware set wins over clear-on-read of status.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fault_result_flag <= 1'b0;
    end else if (ce) begin
      if ((cal_done && cal_fail) || (diag_done && diag_fault)) begin
        fault_result_flag <= 1'b1;
      end else if (reg_rd && reg_addr == ADDR_STATUS) begin
        fault_result_flag <= 1'b0;
      end
    end
  end

  // Read data, valid in the cycle after the read strobe.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        unique case (reg_addr)
          ADDR_STATUS: begin
            reg_rdata               <= {6'h00, loop_mode};
            reg_rdata[ST_FAULT_BIT] <= fault_result_flag;
          end
          ADDR_RATED:  reg_rdata <= rated_reg;
          ADDR_CLAMP:  reg_rdata <= clamp_reg;
          ADDR_COMP:   reg_rdata <= comp_reg;
          ADDR_BEMF:   reg_rdata <= bemf_norm_factor;
          ADDR_FBCTL:  reg_rdata <= fbctl_reg;
          ADDR_CTL1:   reg_rdata <= ctl1_reg;
          ADDR_CTL2:   reg_rdata <= ctl2_reg;
          ADDR_CTL5:   reg_rdata <= ctl5_reg;
          ADDR_OLPER:  reg_rdata <= {1'b0, fixed_drive_period};
          ADDR_PERIOD: reg_rdata <= period_reg;
          default:     reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Time base and resonance tracker
  // ----------------------------------------------------------------

  // One tick every 98.49 us; all loop periods count in ticks.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_reg <= 14'h0000;
    end else if (ce) begin
      if (tick) begin
        tick_cnt_reg <= 14'h0000;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 14'h0001;
      end
    end
  end

  assign tick = (32'(tick_cnt_reg) >= TICK_CYC - 1);

  // Commutation timing for each mode.
  always_comb begin
    fb_half = 8'h01;
    if (drive_time > 5'(zero_cross_window)) begin
      fb_half = 8'(drive_time - 5'(zero_cross_window));
    end
    open_half = 8'({1'b0, fixed_drive_period} >> 1);
    if (open_half == 8'h00) begin
      open_half = 8'h01;
    end
    // Tracking reacts to back-EMF edges only, never to calibration.
    sync    = bemf_zc && bemf_valid && actuator_type_select;
    timeout = tick && (hcnt_reg + 8'h01 >= fb_half);
    open_due = tick && (hcnt_reg + 8'h01 >= open_half);
    unique case (loop_mode)
      LOOP_CLOSED:   comm = actuator_type_select && (sync || timeout);
      LOOP_FALLBACK: comm = sync || timeout;
      LOOP_OPEN:     comm = open_due;
      default:       comm = 1'b0;
    endcase
  end

  // Half-period counter and drive polarity.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hcnt_reg <= 8'h00;
      pol_reg  <= 1'b0;
    end else if (ce) begin
      if (!drive_on || comm) begin
        hcnt_reg <= 8'h00;
      end else if (tick && hcnt_reg != 8'hff) begin
        hcnt_reg <= hcnt_reg + 8'h01;
      end
      if (!drive_on) begin
        pol_reg <= 1'b0;
      end else if (comm) begin
        pol_reg <= !pol_reg;
      end
    end
  end

  // Period is twice the measured half cycle, held when idle.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      period_reg <= 8'h00;
    end else if (ce && drive_on && sync && loop_mode != LOOP_OPEN) begin
      // Updated only on synchronised edges, where it is meaningful.
      period_reg <= hcnt_reg[7] ? 8'hff : {hcnt_reg[6:0], 1'b0};
    end
  end

  // Count of half cycles without a back-EMF crossing.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      unsync_reg <= 2'h0;
    end else if (ce) begin
      if (sync || play_start) begin
        unsync_reg <= 2'h0;
      end else if (loop_mode == LOOP_CLOSED && timeout && unsync_reg != 2'h3) begin
        unsync_reg <= unsync_reg + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Loop mode control
  // ----------------------------------------------------------------

  // Closed, fallback and one-way open-loop transitions.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      loop_mode <= LOOP_IDLE;
    end else if (ce) begin
      if (!drive_on) begin
        loop_mode <= LOOP_IDLE;
      end else begin
        unique case (loop_mode)
          LOOP_IDLE: begin
            loop_mode <= LOOP_CLOSED;
          end
          LOOP_CLOSED: begin
            if (actuator_type_select && timeout && !sync) begin
              if (!auto_fallback_enable) begin
                loop_mode <= LOOP_FALLBACK;
              end else if (unsync_reg >= unsync_cycle_limit) begin
                loop_mode <= LOOP_OPEN;
              end
            end
          end
          LOOP_FALLBACK: begin
            if (sync) begin
              loop_mode <= LOOP_CLOSED;
            end
          end
          LOOP_OPEN: begin
            loop_mode <= LOOP_OPEN;
          end
        endcase
      end
    end
  end

  // Startup window for the boosted gain.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      boost_reg <= 8'h00;
    end else if (ce) begin
      if (play_start || loop_mode == LOOP_IDLE) begin
        boost_reg <= BOOST_TICKS;
      end else if (tick && boost_reg != 8'h00) begin
        boost_reg <= boost_reg - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Amplitude loop
  // ----------------------------------------------------------------

  // Target, feedback error, gain shaping, compensation and clamp.
  always_comb begin
    logic [15:0]        tprod;
    logic [15:0]        fprod;
    logic [7:0]         target;
    logic [7:0]         fb;
    logic signed [9:0]  err;
    logic [5:0]         gain;
    logic signed [17:0] level;
    logic [17:0]        cprod;
    tprod = drive_level * rated_reg + 16'(rated_reg);
    target = tprod[15:8];
    fprod = bemf_mag * bemf_norm_factor;
    fb = fprod[15] ? 8'hff : fprod[14:7];
    err = $signed({2'b00, target}) - $signed({2'b00, fb});
    gain = 6'(fbctl_reg[FB_GAIN_LSB +: 2]) + 6'h01;
    brake_next = 1'b0;
    if (err < 0) begin
      brake_next = 1'b1;
      gain = 6'(gain * (6'(brake_gain_ratio) + 6'h01));
      if (ctl2_reg[C2_STAB_BIT] && fb < 8'(target + BRAKE_NEAR)) begin
        gain = gain >> 1;
      end
    end else if (ctl1_reg[C1_BOOST_BIT] && boost_reg != 8'h00) begin
      gain = gain << 1;
    end
    // Feedback term gives overdrive on rise, reverse drive on brake.
    level = $signed({10'h000, target}) + 18'(err * $signed({1'b0, gain})) / 2;
    if (err < 0) begin
      level = -(level - $signed({10'h000, target}));
    end
    if (level < 0) begin
      level = 18'sh00000;
    end
    cprod = 18'(level) * 18'(comp_reg);
    level = level + $signed(18'(cprod >> 8));
    unique case (loop_mode)
      LOOP_CLOSED: begin
        amp_next = (level > $signed({10'h000, clamp_reg})) ? clamp_reg : level[7:0];
      end
      LOOP_FALLBACK: begin
        amp_next   = clamp_reg;
        brake_next = 1'b0;
      end
      LOOP_OPEN: begin
        amp_next   = (target > clamp_reg) ? clamp_reg : target;
        brake_next = 1'b0;
      end
      default: begin
        amp_next   = 8'h00;
        brake_next = 1'b0;
      end
    endcase
  end

  // Registered drive outputs.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      out_amp   <= 8'h00;
      out_pol   <= 1'b0;
      out_brake <= 1'b0;
    end else if (ce) begin
      out_amp   <= amp_next;
      out_brake <= brake_next;
      out_pol   <= pol_reg ^ brake_next;
    end
  end

endmodule

`default_nettype wire

// ### dv/haptic_closed_loop_control_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module haptic_closed_loop_control_asserts
  import haptic_loop_pkg::*;
#(
  parameter int unsigned TICK_CYC = 4
) (
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic       ce,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       drive_on,
  input wire logic       bemf_valid,
  input wire logic       bemf_zc,
  input wire logic       cal_done,
  input wire logic       cal_fail,
  input wire logic       diag_done,
  input wire logic       diag_fault,
  input wire logic [7:0] out_amp,
  input wire logic       out_brake,
  input wire loop_mode_t loop_mode
);
  // ----------------------------------------------------------------
  // Shadow state
  // ----------------------------------------------------------------
  logic [7:0] clamp_reg;
  logic [7:0] fbctl_reg;
  logic [7:0] ctl5_reg;
  logic       fault_reg;

  // Copies of the registers the loop decisions depend on.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      clamp_reg <= RST_CLAMP;
      fbctl_reg <= RST_FBCTL;
      ctl5_reg  <= RST_CTL5;
    end else if (ce && reg_wr) begin
      if (reg_addr == ADDR_CLAMP) clamp_reg <= reg_wdata;
      if (reg_addr == ADDR_FBCTL) fbctl_reg <= reg_wdata;
      if (reg_addr == ADDR_CTL5) ctl5_reg <= reg_wdata;
    end
  end

  // Fault flag: a failing routine sets it and wins over a clearing read.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fault_reg <= 1'b0;
    end else if (ce && ((cal_done && cal_fail) || (diag_done && diag_fault))) begin
      fault_reg <= 1'b1;
    end else if (ce && reg_rd && reg_addr == ADDR_STATUS) begin
      fault_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  AST_RDATA_ZERO: assert property (ce && !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside the read slot");
  AST_STATUS_READ: assert property (ce && reg_rd && reg_addr == ADDR_STATUS
    |=> reg_rdata[ST_FAULT_BIT] == $past(fault_reg) && reg_rdata[1:0] == $past(loop_mode))
    else $error("status read gives wrong fault flag or mode");
  AST_IDLE: assert property (ce && !drive_on |=> loop_mode == LOOP_IDLE)
    else $error("loop not idle without drive");
  AST_START: assert property ($rose(drive_on) && ce |=> loop_mode == LOOP_CLOSED)
    else $error("drive start did not enter closed loop");
  AST_CLAMP: assert property ($past(clamp_reg, 3) == clamp_reg |-> out_amp <= clamp_reg)
    else $error("drive amplitude above clamp");
  AST_OPEN_NO_BRAKE: assert property (loop_mode == LOOP_OPEN && $past(loop_mode) == LOOP_OPEN |-> !out_brake)
    else $error("braking in open loop");
  AST_OPEN_HOLD: assert property (loop_mode == LOOP_OPEN && drive_on |=> loop_mode == LOOP_OPEN)
    else $error("open loop left while driving");
  AST_OPEN_ENTRY: assert property (loop_mode == LOOP_OPEN && $past(loop_mode) != LOOP_OPEN
    |-> ctl5_reg[C5_AUTO_BIT] && fbctl_reg[FB_TYPE_BIT])
    else $error("open loop entered without auto enable");
  AST_FB_ENTRY: assert property (loop_mode == LOOP_FALLBACK && $past(loop_mode) != LOOP_FALLBACK
    |-> !ctl5_reg[C5_AUTO_BIT] && fbctl_reg[FB_TYPE_BIT])
    else $error("fallback entered in wrong configuration");
  AST_RESYNC: assert property (ce && drive_on && loop_mode == LOOP_FALLBACK && bemf_valid && bemf_zc
    && fbctl_reg[FB_TYPE_BIT] |=> loop_mode == LOOP_CLOSED)
    else $error("valid crossing did not restore closed loop");

  CV_OPEN: cover property (loop_mode == LOOP_OPEN);
  CV_RESYNC: cover property (loop_mode == LOOP_FALLBACK ##1 loop_mode == LOOP_CLOSED);
  CV_FAULT: cover property (ce && reg_rd && reg_addr == ADDR_STATUS && fault_reg);
endmodule
`default_nettype wire

// ### dv/haptic_actuator_model.sv
`timescale 1ns/1ps
`default_nettype none
module haptic_actuator_model (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       live,
  input  wire logic [7:0] half_cyc,
  input  wire logic [7:0] out_amp,
  output var  logic       bemf_valid,
  output var  logic       bemf_zc,
  output var  logic [7:0] bemf_mag
);
  logic [7:0] cnt_reg;

  // A moving actuator crosses zero every half_cyc cycles; a still one gives
  // no valid back-EMF and no magnitude, so the loop never brakes on noise.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_reg    <= 8'h00;
      bemf_valid <= 1'b0;
      bemf_zc    <= 1'b0;
      bemf_mag   <= 8'h00;
    end else begin
      cnt_reg    <= (cnt_reg + 8'h01 >= half_cyc) ? 8'h00 : cnt_reg + 8'h01;
      bemf_valid <= live;
      bemf_zc    <= live && (cnt_reg == 8'h00);
      bemf_mag   <= live ? (out_amp >> 1) : 8'h00;
    end
  end
endmodule
`default_nettype wire

// ### dv/test_haptic_closed_loop_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_haptic_closed_loop_control import haptic_loop_pkg::*;;
  localparam int T = 4;
  localparam logic [7:0] RA [9] = '{ADDR_RATED, ADDR_CLAMP, ADDR_COMP, ADDR_BEMF, ADDR_FBCTL, ADDR_CTL1,
                                    ADDR_CTL2, ADDR_CTL5, ADDR_OLPER};
  localparam logic [7:0] RV [9] = '{RST_RATED, RST_CLAMP, RST_COMP, RST_BEMF, RST_FBCTL, RST_CTL1,
                                    RST_CTL2, RST_CTL5, {1'b0, RST_OLPER}};
  localparam logic [7:0] WV [9] = '{8'h90, 8'hc8, 8'h33, 8'h80, 8'hb4, 8'h08, 8'h02, 8'h00, 8'h0a};
  logic       clk_sys, rstn, ce, reg_wr, reg_rd, play_start, drive_on, live, bemf_valid, bemf_zc;
  logic       cal_done, cal_fail, diag_done, diag_fault, out_pol, out_brake;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, drive_level, bemf_mag, cal_comp, cal_bemf, out_amp;
  logic [7:0] half_cyc, d, p;
  loop_mode_t loop_mode;
  int         fails, total_checks, cyc, n, tog[4];

  haptic_closed_loop_control #(.TICK_CYC(T)) haptic_closed_loop_control_i (.clk_sys, .rstn, .ce, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .play_start, .drive_on, .drive_level, .bemf_valid, .bemf_zc,
    .bemf_mag, .cal_done, .cal_fail, .cal_comp, .cal_bemf, .diag_done, .diag_fault, .out_amp, .out_pol,
    .out_brake, .loop_mode);
  haptic_actuator_model haptic_actuator_model_i (.clk_sys, .rstn, .live, .half_cyc, .out_amp, .bemf_valid,
    .bemf_zc, .bemf_mag);

  // Clock and a cycle ceiling that cuts a hang short.
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chkr(input string nm, input int lo, hi, input logic [9:0] got);
    total_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fails++;
      $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rc(input logic [7:0] a, e, input string nm);
    rd(a);
    chk(nm, e, d);
  endtask
  // Waits for a loop mode, counting drive commutations on the way.
  task automatic wait_mode(input loop_mode_t m, output int t);
    logic q;
    t = 0;
    q = out_pol;
    for (int i = 0; i < 2000 && loop_mode !== m; i++) begin
      @(posedge clk_sys);
      #1;
      if (out_pol !== q) t++;
      q = out_pol;
    end
    chk("loop mode", {6'h00, m}, {6'h00, loop_mode});
  endtask
  // Cycles between two polarity changes, after aligning to a first one.
  task automatic gap(output int g);
    logic q;
    for (int k = 0; k < 2; k++) begin
      q = out_pol;
      g = 0;
      while (out_pol === q && g < 600) begin
        @(posedge clk_sys);
        #1;
        g++;
      end
    end
  endtask
  task automatic routine_end(input logic cal, bad, input logic [7:0] exp);
    @(posedge clk_sys);
    cal_done <= cal;
    diag_done <= !cal;
    {cal_fail, diag_fault} <= {bad, bad};
    cal_comp <= 8'h21;
    cal_bemf <= 8'h42;
    @(posedge clk_sys);
    {cal_done, diag_done} <= 2'b00;
    rd(ADDR_STATUS);
    chk("fault flag", exp, {7'h00, d[ST_FAULT_BIT]});
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {clk_sys, rstn, reg_wr, reg_rd, play_start, drive_on, live, cal_done, cal_fail, diag_done, diag_fault} = '0;
    {reg_addr, reg_wdata, cal_comp, cal_bemf} = '0;
    {ce, drive_level, half_cyc} = {1'b1, 8'hff, 8'h10};
    {fails, total_checks, cyc} = '0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    for (int i = 0; i < 9; i++) rc(RA[i], RV[i], "reset value");
    for (int i = 0; i < 9; i++) begin
      wr(RA[i], WV[i]);
      rc(RA[i], WV[i], "readback");
    end
    wr(8'h05, 8'hff);
    rc(8'h05, 8'h00, "unmapped");
    rd(ADDR_PERIOD);
    p = d;
    wr(ADDR_PERIOD, ~p);
    rc(ADDR_PERIOD, p, "period read-only");
    wr(ADDR_STATUS, 8'hff);
    rc(ADDR_STATUS, 8'h00, "status read-only");
    @(posedge clk_sys);
    ce <= 1'b0;
    wr(ADDR_COMP, 8'h5a);
    ce <= 1'b1;
    rc(ADDR_COMP, 8'h33, "frozen write");
    // Rotating actuator: no crossings yet the loop stays closed.
    wr(ADDR_FBCTL, 8'h34);
    @(posedge clk_sys);
    drive_on <= 1'b1;
    repeat (200) @(posedge clk_sys);
    #1 chk("rotating mode", {6'h00, LOOP_CLOSED}, {6'h00, loop_mode});
    @(posedge clk_sys);
    drive_on <= 1'b0;
    // Resonant actuator silent, then live.
    wr(ADDR_FBCTL, 8'hb4);
    @(posedge clk_sys);
    drive_on <= 1'b1;
    wait_mode(LOOP_FALLBACK, n);
    gap(n);
    chkr("fallback half period", 5 * T, 7 * T, n);
    chk("fallback amp", 8'hc8, out_amp);
    @(posedge clk_sys);
    live <= 1'b1;
    wait_mode(LOOP_CLOSED, n);
    repeat (100) @(posedge clk_sys);
    rd(ADDR_PERIOD);
    p = d;
    chkr("resonance period", 6, 10, {2'b00, p});
    // Envelope dropped below the moving actuator's back-EMF: the loop brakes.
    @(posedge clk_sys);
    drive_level <= 8'h00;
    repeat (4) @(posedge clk_sys);
    #1 chk("closed brake", 8'h01, {7'h00, out_brake});
    @(posedge clk_sys);
    {drive_on, live, drive_level} <= {2'b00, 8'hff};
    repeat (10) @(posedge clk_sys);
    rc(ADDR_PERIOD, p, "held period");
    // Auto open loop at every tolerated-cycle limit.
    for (int l = 0; l < 4; l++) begin
      wr(ADDR_CTL5, {l[1:0], 6'h20});
      @(posedge clk_sys);
      {drive_on, play_start} <= 2'b11;
      @(posedge clk_sys);
      play_start <= 1'b0;
      wait_mode(LOOP_OPEN, tog[l]);
      gap(n);
      chkr("open half period", 4 * T, 6 * T, n);
      chk("open amp", 8'h90, out_amp);
      if (l == 3) begin
        wr(ADDR_RATED, 8'hf0);
        wr(ADDR_CLAMP, 8'h60);
        repeat (4) @(posedge clk_sys);
        #1 chk("clamped amp", 8'h60, out_amp);
      end
      @(posedge clk_sys);
      drive_on <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
    for (int l = 0; l < 4; l++) chkr("unsynced cycles", l, l, tog[l]);
    routine_end(1'b1, 1'b1, 8'h01);
    routine_end(1'b0, 1'b1, 8'h01);
    routine_end(1'b1, 1'b0, 8'h00);
    rc(ADDR_COMP, 8'h21, "loss factor");
    rc(ADDR_BEMF, 8'h42, "norm factor");
    give_verdict();
  end
endmodule

bind haptic_closed_loop_control haptic_closed_loop_control_asserts #(.TICK_CYC(TICK_CYC))
  haptic_closed_loop_control_asserts_i (.clk_sys, .rstn, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .drive_on, .bemf_valid, .bemf_zc, .cal_done, .cal_fail, .diag_done, .diag_fault, .out_amp,
  .out_brake, .loop_mode);
`default_nettype wire
